// ===== tgic_counters.sv
/*
  tgic_counters: period, phase and gate interval counters behind an APB
  slave, with results also served to the acquisition channel list.
  assumes tach, gate and sample strobe inputs are synchronous to i_clock
  and that the channel list asks for at most one channel per cycle.
*/
// Local design decisions: the APB register port and the register offsets.
// What this block does
// - period counter ticks at twelve megahertz reference
// - period edge selectable rising or falling
// - count from first selected edge to next
// - hold result until read; read relaunches
// - pending reads give zero or prior result
// - stale marking: top bit flags pending
// - marking off forces top bit zero
// - period result served as channel four
// - results act like ordinary acquisition channels
// - count equals reference periods plus one
// - phase result served as channel five
// - phase counter ticks at forty-eight megahertz
// - phase start/stop: sample, tach rise, fall
// - self-clear picks zero or previous between
// - gate result channel six, forty-eight megahertz
// - gate times sample/gate edge intervals
// - gate start/stop: sample, gate rise, fall
// - same-edge stop never restarts measurement
`timescale 1ns/1ps
module tgic_counters
  import tgic_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // pulse inputs
  input wire logic i_tach,
  input wire logic i_gate,
  input wire logic i_sample_strobe,
  // acquisition channel list request and answer
  input wire logic i_chan_req,
  input wire logic [2:0] i_chan_sel,
  output logic o_chan_valid,
  output logic [31:0] o_chan_data
);
  import tgic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [31:0] ctrl;
    logic tach_prev;
    logic gate_prev;
    logic [ACC_W-1:0] acc_slow;
    logic [ACC_W-1:0] acc_fast;
    tgic_per_state_type per_st;
    logic [30:0] per_cnt;
    logic [30:0] per_res;
    logic ph_busy;
    logic ph_fresh;
    logic [31:0] ph_cnt;
    logic [31:0] ph_res;
    logic gt_busy;
    logic gt_fresh;
    logic [31:0] gt_cnt;
    logic [31:0] gt_res;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic chan_valid;
    logic [31:0] chan_data;
  } tgic_state_type;

  tgic_state_type s_q;
  tgic_state_type s_d;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // fractional reference tick: bit ACC_W is the tick, low bits the phase
  function automatic logic [ACC_W:0] ref_step(input logic [ACC_W-1:0] acc,
                                              input logic [ACC_W-1:0] inc);
    logic [ACC_W:0] sum;
    sum = {1'b0, acc} + {1'b0, inc};
    if (sum >= {1'b0, ACC_W'(CLK_KHZ)})
      ref_step = {1'b1, sum[ACC_W-1:0] - ACC_W'(CLK_KHZ)};
    else
      ref_step = {1'b0, sum[ACC_W-1:0]};
  endfunction

  // pick one of sample strobe, rising or falling edge
  function automatic logic evt_pick(input logic [1:0] sel,
                                    input logic smp,
                                    input logic rise,
                                    input logic fall);
    if (sel == EVT_SAMPLE)
      evt_pick = smp;
    else if (sel == EVT_RISE)
      evt_pick = rise;
    else if (sel == EVT_FALL)
      evt_pick = fall;
    else
      evt_pick = 1'b0;
  endfunction

  // value returned by the phase or gate counter on a read
  function automatic logic [31:0] ivl_read(input logic fresh,
                                           input logic keep,
                                           input logic [31:0] res);
    if (fresh || keep)
      ivl_read = res;
    else
      ivl_read = 32'h0000_0000;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    logic [ACC_W:0] slow_step;
    logic [ACC_W:0] fast_step;
    logic tick_slow;
    logic tick_fast;
    logic run;
    logic tach_rise;
    logic tach_fall;
    logic gate_rise;
    logic gate_fall;
    logic per_edge;
    logic ph_start;
    logic ph_stop;
    logic gt_start;
    logic gt_stop;
    logic apb_prep;
    logic [31:0] per_val;
    logic [31:0] ph_val;
    logic [31:0] gt_val;
    logic [31:0] rd_val;
    logic rd_per;
    logic rd_ph;
    logic rd_gt;
    logic [31:0] ch_val;
    slow_step = '0;
    fast_step = '0;
    tick_slow = 1'b0;
    tick_fast = 1'b0;
    run = 1'b0;
    tach_rise = 1'b0;
    tach_fall = 1'b0;
    gate_rise = 1'b0;
    gate_fall = 1'b0;
    per_edge = 1'b0;
    ph_start = 1'b0;
    ph_stop = 1'b0;
    gt_start = 1'b0;
    gt_stop = 1'b0;
    apb_prep = 1'b0;
    per_val = '0;
    ph_val = '0;
    gt_val = '0;
    rd_val = '0;
    rd_per = 1'b0;
    rd_ph = 1'b0;
    rd_gt = 1'b0;
    ch_val = '0;
    s_d = s_q;

    // reference ticks and edge detection
    slow_step = ref_step(s_q.acc_slow, ACC_W'(REF_SLOW_KHZ));
    fast_step = ref_step(s_q.acc_fast, ACC_W'(REF_FAST_KHZ));
    tick_slow = slow_step[ACC_W];
    tick_fast = fast_step[ACC_W];
    s_d.acc_slow = slow_step[ACC_W-1:0];
    s_d.acc_fast = fast_step[ACC_W-1:0];
    s_d.tach_prev = i_tach;
    s_d.gate_prev = i_gate;
    tach_rise = i_tach && !s_q.tach_prev;
    tach_fall = !i_tach && s_q.tach_prev;
    gate_rise = i_gate && !s_q.gate_prev;
    gate_fall = !i_gate && s_q.gate_prev;
    run = s_q.ctrl[CTL_RUN];
    per_edge = s_q.ctrl[CTL_PER_FALL] ? tach_fall : tach_rise;

    // phase and gate event selection
    ph_start = evt_pick(s_q.ctrl[CTL_PH_START +: 2], i_sample_strobe,
                        tach_rise, tach_fall);
    ph_stop = evt_pick(s_q.ctrl[CTL_PH_STOP +: 2], i_sample_strobe,
                       tach_rise, tach_fall);
    gt_start = evt_pick(s_q.ctrl[CTL_GT_START +: 2], i_sample_strobe,
                        gate_rise, gate_fall);
    gt_stop = evt_pick(s_q.ctrl[CTL_GT_STOP +: 2], i_sample_strobe,
                       gate_rise, gate_fall);

    // read values of the three results
    if (s_q.per_st == PER_DONE)
      per_val = {1'b0, s_q.per_res};
    else
      per_val = {!s_q.ctrl[CTL_STALE_OFF],
                 s_q.ctrl[CTL_PER_KEEP] ? s_q.per_res : 31'h0000_0000};
    ph_val = ivl_read(s_q.ph_fresh, s_q.ctrl[CTL_PH_KEEP], s_q.ph_res);
    gt_val = ivl_read(s_q.gt_fresh, s_q.ctrl[CTL_GT_KEEP], s_q.gt_res);

    // apb: answer one cycle into the access phase
    apb_prep = i_psel && i_penable && !s_q.pready;
    s_d.pready = apb_prep;
    s_d.pslverr = 1'b0;
    if (apb_prep)
    begin
      if (i_paddr == OFS_CTRL)
      begin
        rd_val = s_q.ctrl;
        if (i_pwrite)
          s_d.ctrl = i_pwdata & CTL_WMASK;
      end
      else if (i_paddr == OFS_PERIOD)
      begin
        rd_val = per_val;
        rd_per = !i_pwrite;
      end
      else if (i_paddr == OFS_PHASE)
      begin
        rd_val = ph_val;
        rd_ph = !i_pwrite;
      end
      else if (i_paddr == OFS_GATE)
      begin
        rd_val = gt_val;
        rd_gt = !i_pwrite;
      end
      else if (i_paddr == OFS_STATUS)
        rd_val = {27'h0000000, s_q.gt_fresh, s_q.ph_fresh,
                  s_q.gt_busy || s_q.ph_busy, s_q.per_st};
      else
        s_d.pslverr = 1'b1;
      s_d.prdata = i_pwrite ? 32'h0000_0000 : rd_val;
    end

    // channel list: pseudo-channels look like any other channel
    if (i_chan_sel == CHAN_PERIOD)
      ch_val = per_val;
    else if (i_chan_sel == CHAN_PHASE)
      ch_val = ph_val;
    else if (i_chan_sel == CHAN_GATE)
      ch_val = gt_val;
    else
      ch_val = 32'h0000_0000;
    s_d.chan_valid = i_chan_req;
    if (i_chan_req)
      s_d.chan_data = ch_val;
    rd_per = rd_per || (i_chan_req && i_chan_sel == CHAN_PERIOD);
    rd_ph = rd_ph || (i_chan_req && i_chan_sel == CHAN_PHASE);
    rd_gt = rd_gt || (i_chan_req && i_chan_sel == CHAN_GATE);

    // period counter
    case (s_q.per_st)
      PER_IDLE:
      begin
        if (run)
          s_d.per_st = PER_ARM;
      end
      PER_ARM:
      begin
        if (per_edge)
        begin
          s_d.per_cnt = 31'h0000_0001;
          s_d.per_st = PER_COUNT;
        end
      end
      PER_COUNT:
      begin
        if (per_edge)
        begin
          s_d.per_res = s_q.per_cnt;
          s_d.per_st = PER_DONE;
        end
        else if (tick_slow)
          s_d.per_cnt = s_q.per_cnt + 31'h0000_0001;
      end
      PER_DONE:
      begin
        if (rd_per)
          s_d.per_st = PER_ARM;
      end
      default:
        s_d.per_st = PER_IDLE;
    endcase

    // phase counter: a stop while busy wins over a restart
    if (s_q.ph_busy)
    begin
      if (ph_stop)
      begin
        s_d.ph_busy = 1'b0;
        s_d.ph_res = s_q.ph_cnt;
      end
      else if (tick_fast)
        s_d.ph_cnt = s_q.ph_cnt + 32'h0000_0001;
    end
    else if (run && ph_start)
    begin
      s_d.ph_busy = 1'b1;
      s_d.ph_cnt = 32'h0000_0000;
    end
    if (s_q.ph_busy && ph_stop)
      s_d.ph_fresh = 1'b1;
    else if (rd_ph)
      s_d.ph_fresh = 1'b0;

    // gate counter: stop edge never doubles as the next start
    if (s_q.gt_busy)
    begin
      if (gt_stop)
      begin
        s_d.gt_busy = 1'b0;
        s_d.gt_res = s_q.gt_cnt;
      end
      else if (tick_fast)
        s_d.gt_cnt = s_q.gt_cnt + 32'h0000_0001;
    end
    else if (run && gt_start)
    begin
      s_d.gt_busy = 1'b1;
      s_d.gt_cnt = 32'h0000_0000;
    end
    if (s_q.gt_busy && gt_stop)
      s_d.gt_fresh = 1'b1;
    else if (rd_gt)
      s_d.gt_fresh = 1'b0;

    // stopping the run parks every counter cleared
    if (!run)
    begin
      s_d.per_st = PER_IDLE;
      s_d.per_cnt = 31'h0000_0000;
      s_d.ph_busy = 1'b0;
      s_d.ph_cnt = 32'h0000_0000;
      s_d.gt_busy = 1'b0;
      s_d.gt_cnt = 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET;
      s_q.per_st <= PER_IDLE;
    end
    else
      s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, straight from the state register
  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_chan_valid = s_q.chan_valid;
  assign o_chan_data = s_q.chan_data;

endmodule // tgic_counters

// ===== tgic_pkg.sv
/*
  tgic_pkg: register map, control field positions, reset values and
  reference-rate constants for the tach/gate interval counter block.
  assumes a single 125 MHz system clock and a 32-bit APB register bus.
*/
package tgic_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and reference rates, in kHz
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned REF_SLOW_KHZ = 12000;
  localparam int unsigned REF_FAST_KHZ = 48000;
  localparam int unsigned ACC_W = 17;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_PHASE = 8'h08;
  localparam logic [7:0] OFS_GATE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // control register field positions
  localparam int unsigned CTL_RUN = 0;
  localparam int unsigned CTL_PER_FALL = 1;
  localparam int unsigned CTL_PER_KEEP = 2;
  localparam int unsigned CTL_STALE_OFF = 3;
  localparam int unsigned CTL_PH_START = 4;
  localparam int unsigned CTL_PH_STOP = 6;
  localparam int unsigned CTL_PH_KEEP = 8;
  localparam int unsigned CTL_GT_START = 9;
  localparam int unsigned CTL_GT_STOP = 11;
  localparam int unsigned CTL_GT_KEEP = 13;
  localparam logic [31:0] CTL_WMASK = 32'h0000_3FFF;
  // phase: sample start, tach rising stop; gate: sample start, gate rising
  localparam logic [31:0] CTRL_RESET = 32'h0000_0840;

  ////////////////////////////////////////////////////////////////////////////
  // event selector codes and pseudo-channel numbers
  localparam logic [1:0] EVT_SAMPLE = 2'h0;
  localparam logic [1:0] EVT_RISE = 2'h1;
  localparam logic [1:0] EVT_FALL = 2'h2;
  localparam logic [2:0] CHAN_PERIOD = 3'h4;
  localparam logic [2:0] CHAN_PHASE = 3'h5;
  localparam logic [2:0] CHAN_GATE = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // period counter states
  typedef enum logic [1:0] {
    PER_IDLE = 2'b00,
    PER_ARM = 2'b01,
    PER_COUNT = 2'b10,
    PER_DONE = 2'b11
  } tgic_per_state_type;

endpackage : tgic_pkg

// ===== tgic_monitor.sv
/* tgic_monitor: bus and channel timing checks on the counter block.
   assumes the port names of tgic_counters; bound at file foot. */
`timescale 1ns/1ps
module tgic_monitor (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // bus side
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [7:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // channel side
  input wire logic i_chan_req,
  input wire logic [2:0] i_chan_sel,
  input wire logic o_chan_valid,
  input wire logic [31:0] o_chan_data
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  logic acc;
  // access cycle still waiting for its answer
  assign acc = i_psel && i_penable && !o_pready;
  ////////////////////////////////////////////////////////////////////////////
  // bus timing
  ready_wait_a: assert property (acc |=> o_pready)
    else $error("bus answer late");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  ready_cause_a: assert property (o_pready |-> $past(i_psel && i_penable))
    else $error("ready without access");
  err_unmapped_a: assert property (acc && i_paddr > 8'h10 |=> o_pslverr)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (acc && i_paddr <= 8'h10
    && i_paddr[1:0] == 2'h0 |=> !o_pslverr)
    else $error("mapped access refused");
  ////////////////////////////////////////////////////////////////////////////
  // channel timing
  chan_answer_a: assert property (i_chan_req |=> o_chan_valid)
    else $error("channel answer missing");
  chan_cause_a: assert property (o_chan_valid |-> $past(i_chan_req))
    else $error("channel answer unasked");
  chan_unused_a: assert property (i_chan_req && (i_chan_sel < 3'h4
    || i_chan_sel == 3'h7) |=> o_chan_data == 32'h0)
    else $error("unused channel not zero");
  reset_quiet_a: assert property ($rose(i_reset_n)
    |-> !o_pready && !o_chan_valid)
    else $error("output active after reset");
  // main scenarios
  cover property (o_pslverr);
  cover property (o_chan_valid && i_chan_sel == 3'h6);
  cover property (o_pready ##1 !o_pready);
endmodule // tgic_monitor

bind tgic_counters tgic_monitor tgic_monitor_i (
  .i_clock(i_clock),
  .i_reset_n(i_reset_n),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_paddr(i_paddr),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .i_chan_req(i_chan_req),
  .i_chan_sel(i_chan_sel),
  .o_chan_valid(o_chan_valid),
  .o_chan_data(o_chan_data)
);

// ===== tgic_pulse_src.sv
/* tgic_pulse_src: far-side source of tach, gate and sample strobe.
   assumes one clock; all levels change just after a rising edge. */
`timescale 1ns/1ps
module tgic_pulse_src #(
  parameter int PER = 1250,
  parameter int STRB = 1125,
  parameter int G_ON = 300,
  parameter int G_OFF = 550
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // pulse outputs
  output logic o_tach,
  output logic o_gate,
  output logic o_strobe
);
  int cnt;
  // position in one tach cycle sets every pulse
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cnt <= 0;
      o_tach <= 1'h0;
      o_gate <= 1'h0;
      o_strobe <= 1'h0;
    end
    else
    begin
      cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
      o_tach <= cnt < PER / 2;
      o_gate <= cnt >= G_ON && cnt < G_OFF;
      o_strobe <= cnt == STRB; // one pulse, a sample before tach rise
    end
  end
endmodule // tgic_pulse_src

// ===== tgic_counters_test.sv
/* tgic_counters_test: bus and channel tests of the interval counters.
   assumes the pulse source gives a 1250-cycle tach and gate cycle. */
`timescale 1ns/1ps
module tgic_counters_test;
  import tgic_pkg::*;
  logic i_clock, i_reset_n, i_psel, i_penable, i_pwrite, e;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, o_chan_data, q, v1;
  logic o_pready, o_pslverr, i_tach, i_gate, i_sample_strobe;
  logic i_chan_req, o_chan_valid;
  logic [2:0] i_chan_sel;
  int fails, checks;
  // clock
  initial
  begin
    i_clock = 1'h0;
    forever #4 i_clock = ~i_clock;
  end
  tgic_counters tgic_counters_i (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_tach(i_tach),
    .i_gate(i_gate), .i_sample_strobe(i_sample_strobe),
    .i_chan_req(i_chan_req), .i_chan_sel(i_chan_sel),
    .o_chan_valid(o_chan_valid), .o_chan_data(o_chan_data));
  tgic_pulse_src tgic_pulse_src_i (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .o_tach(i_tach), .o_gate(i_gate),
    .o_strobe(i_sample_strobe));
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one bus transfer, waits for ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'h1;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (o_pready !== 1'h1);
    chk(n, 32'h2); // one wait state, then ready
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clock);
  endtask
  // one channel list request
  task chan(input logic [2:0] s);
    i_chan_req <= 1'h1;
    i_chan_sel <= s;
    @(posedge i_clock);
    i_chan_req <= 1'h0;
    @(posedge i_clock);
    chk(o_chan_valid, 32'h1);
    q = o_chan_data;
  endtask
  // stop, then restart with a new setup
  task cfg(input logic [31:0] c);
    apb(1'h1, OFS_CTRL, 32'h0);
    apb(1'h1, OFS_CTRL, c);
  endtask
  // align just after a gate fall
  task to_fall;
    @(negedge i_gate);
    repeat (10) @(posedge i_clock);
  endtask
  task end_sim;
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // tests
  initial
  begin
    {i_reset_n, i_psel, i_penable, i_pwrite, i_chan_req} = 5'h0;
    i_paddr = 8'h0;
    i_pwdata = 32'h0;
    i_chan_sel = 3'h0;
    fails = 0;
    checks = 0;
    repeat (6) @(posedge i_clock);
    i_reset_n <= 1'h1;
    @(posedge i_clock);
    apb(1'h0, OFS_CTRL, 32'h0); chk(q, CTRL_RESET);
    apb(1'h0, OFS_STATUS, 32'h0); chk(q, 32'h0);
    apb(1'h0, 8'h20, 32'h0); chk(e, 32'h1);
    cfg(32'h0000_1241);
    apb(1'h0, OFS_PERIOD, 32'h0); chk(q, 32'h8000_0000);
    repeat (3) to_fall;
    apb(1'h0, OFS_PERIOD, 32'h0); chk(q, 32'h79);
    apb(1'h0, OFS_PERIOD, 32'h0); chk(q, 32'h8000_0000);
    repeat (2) to_fall;
    apb(1'h0, OFS_STATUS, 32'h0); chk(q, 32'h1B);
    chan(3'h4); chk(q, 32'h79);
    chan(3'h5); chk(q >= 32'h2F && q <= 32'h31, 32'h1);
    chan(3'h6); chk(q, 32'h60);
    chan(3'h6); chk(q, 32'h0);
    chan(3'h7); chk(q, 32'h0);
    cfg(32'h0000_332F);
    repeat (3) to_fall;
    apb(1'h0, OFS_PERIOD, 32'h0); chk(q, 32'h79);
    apb(1'h0, OFS_PERIOD, 32'h0); chk(q, 32'h79);
    chan(3'h6); chk(q, 32'h60);
    chan(3'h6); chk(q, 32'h60);
    chan(3'h5); chk(q, 32'hC0);
    cfg(32'h0000_0A41);
    to_fall;
    chan(3'h6);
    to_fall;
    chan(3'h6);
    v1 = q;
    to_fall;
    chan(3'h6);
    // exactly one of two gate cycles completes a measurement
    chk((v1 === 32'h0 && q === 32'h1E0) || (v1 === 32'h1E0 && q === 32'h0),
      32'h1);
    end_sim;
  end
  // watchdog
  initial
  begin
    repeat (40000) @(posedge i_clock);
    fails++;
    end_sim;
  end
endmodule // tgic_counters_test
